// ### rtl/pwdc_out_prot.sv
// PWM output mapper, switching modes, soft start and DC protection
//
// Notes on behaviour
// - Each output pair takes any internal channel chosen by its map register.
// - Two-level mode serves half-bridge and full-bridge stages alike.
// - Asynchronous two-level pairs drive A and B as exact complements.
// - Synchronous two-level pairs drive A and B identically.
// - Biased bridge mode is for bridge-tied loads only.
// - Biased bridge mode never emits pulses shorter than the minimum length.
// - Soft start ramps duty from 1 of 128 high up to half.
// - Step repeat count sets PWM periods per soft start step.
// - Checksum mismatch sets the checksum error flag.
// - Modulation index held beyond limit too long sets its error flag.
// - Modulation duty register sets the index monitoring threshold.
// - Protection checks only flag errors, never alter the bridge outputs.
// - Writing one to the DC soft reset bit reinitialises everything.
// - Fixed DC cut filter removes content below about 0.6 hertz, its corner lying under one hertz.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
module pwdc_out_prot #(
  parameter int NCH              = 2,
  parameter int MOD_HOLD_PERIODS = pwdc_pkg::MOD_HOLD_DEF,
  parameter int DC_SHIFT         = pwdc_pkg::DC_CUT_SHIFT
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire pwdc_pkg::pwdc_avs_req_s avs_req_in,
  output logic [31:0]                  avs_readdata_out,
  output logic                         avs_waitrequest_out,
  input  wire logic [NCH-1:0][7:0]     pwm_duty_in,
  input  wire logic [63:0]             coef_sum_in,
  input  wire logic                    coef_sum_valid_in,
  output logic [1:0]                   bridge_output_a_out,
  output logic [1:0]                   bridge_output_b_out,
  output logic                         dc_soft_reset_out,
  output logic                         irq_out
);

  localparam int ACC_W = 10 + DC_SHIFT;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                        bus_wait;
    logic [31:0]                 rdata;
    logic                        soft_rst;
    logic [6:0]                  cnt;
    logic                        pwm_switch_off_bit;
    logic [1:0]                  mode;
    logic [1:0][7:0]             map;
    logic [6:0]                  minimum_linear_pulse_length;
    logic                        soft_start_enable_bit;
    logic [6:0]                  step_repeat_count;
    logic [6:0]                  mod_duty;
    logic [7:0][7:0]             csum_ref;
    logic [1:0]                  err;
    logic [2:0]                  sts;
    logic [2:0]                  msk;
    logic                        ss_act;
    logic [7:0]                  ss_duty;
    logic [6:0]                  ss_rep;
    logic [NCH-1:0][ACC_W-1:0]   acc;
    logic [NCH-1:0][7:0]         y;
    logic [15:0]                 mi_cnt;
    logic [1:0]                  a;
    logic [1:0]                  b;
    logic                        irq;
  } pwdc_state_s;

  pwdc_state_s st_q;
  pwdc_state_s st_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic pwdc_state_s rst_state();
    pwdc_state_s s;
    s                             = '0;
    s.bus_wait                    = 1'b1;
    s.pwm_switch_off_bit          = pwdc_pkg::RST_OFF;
    s.mode                        = pwdc_pkg::RST_MODE;
    s.map[0]                      = pwdc_pkg::RST_MAP0;
    s.map[1]                      = pwdc_pkg::RST_MAP1;
    s.minimum_linear_pulse_length = pwdc_pkg::RST_MLP;
    s.soft_start_enable_bit       = pwdc_pkg::RST_SS[pwdc_pkg::SS_EN_BIT];
    s.step_repeat_count           = pwdc_pkg::RST_SS[6:0];
    s.mod_duty                    = pwdc_pkg::RST_MOD_DUTY;
    for (int c = 0; c < NCH; c++)
    begin
      s.y[c] = pwdc_pkg::HALF_DUTY;
    end
    return s;
  endfunction : rst_state

  function automatic logic [7:0] abs_dev(input logic [7:0] d);
    return (d >= pwdc_pkg::HALF_DUTY) ? d - pwdc_pkg::HALF_DUTY : pwdc_pkg::HALF_DUTY - d;
  endfunction : abs_dev

  function automatic logic [7:0] to_duty(input logic signed [ACC_W-1:0] v);
    if (v > $signed(ACC_W'(64)))
      return 8'h80;
    else if (v < -$signed(ACC_W'(64)))
      return 8'h00;
    else
      return 8'(v + $signed(ACC_W'(64)));
  endfunction : to_duty

  // ---------------------------------------------------------------
  // Output pair formers
  // ---------------------------------------------------------------
  logic [1:0][7:0] pair_duty;
  logic [1:0]      pair_a;
  logic [1:0]      pair_b;

  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (st_q.ss_act)
        pair_duty[p] = st_q.ss_duty;
      else if (int'(st_q.map[p]) < NCH)
        pair_duty[p] = st_q.y[st_q.map[p]];
      else
        pair_duty[p] = pwdc_pkg::HALF_DUTY;
    end
  end

  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    pwdc_pair_gen u_pair (
      .cnt_in  (st_q.cnt),
      .duty_in (pair_duty[p]),
      .mode_in (st_q.mode),
      .mlp_in  (st_q.minimum_linear_pulse_length),
      .a_out   (pair_a[p]),
      .b_out   (pair_b[p])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [7:0]                idx;
  logic [7:0]                rd_byte;
  logic                      wrap;
  logic                      mi_hit;
  logic                      acc_go;
  logic [7:0]                wdat;
  logic signed [ACC_W-1:0]   xv;
  logic signed [ACC_W-1:0]   yv;

  always_comb
  begin
    st_d   = st_q;
    idx    = avs_req_in.address[pwdc_pkg::AW-1:2];
    wdat   = avs_req_in.writedata[7:0];
    wrap   = st_q.cnt == 7'h7f;
    mi_hit = 1'b0;
    acc_go = avs_req_in.write && avs_req_in.byteenable[0] && !st_q.bus_wait;
    xv     = '0;
    yv     = '0;

    // Register read mux
    case (idx)
      pwdc_pkg::REG_OUT_CTRL:   rd_byte = {7'h00, st_q.pwm_switch_off_bit};
      pwdc_pkg::REG_OUT_MODE:   rd_byte = {6'h00, st_q.mode};
      pwdc_pkg::REG_MAP0:       rd_byte = st_q.map[0];
      pwdc_pkg::REG_MAP1:       rd_byte = st_q.map[1];
      pwdc_pkg::REG_MLP:        rd_byte = {1'b0, st_q.minimum_linear_pulse_length};
      pwdc_pkg::REG_SOFT_START: rd_byte = {st_q.soft_start_enable_bit, st_q.step_repeat_count};
      pwdc_pkg::REG_MOD_DUTY:   rd_byte = {1'b0, st_q.mod_duty};
      pwdc_pkg::REG_DC_ERR:     rd_byte = {6'h00, st_q.err};
      pwdc_pkg::REG_IRQ_STS:    rd_byte = {5'h00, st_q.sts};
      pwdc_pkg::REG_IRQ_MSK:    rd_byte = {5'h00, st_q.msk};
      default:
      begin
        if (idx >= pwdc_pkg::REG_CSUM_FIRST && idx <= pwdc_pkg::REG_CSUM_LAST)
          rd_byte = st_q.csum_ref[3'(idx - pwdc_pkg::REG_CSUM_FIRST)];
        else
          rd_byte = 8'h00;
      end
    endcase

    // Bus handshake: one wait cycle, answer on the next
    st_d.bus_wait = 1'b1;
    if ((avs_req_in.read || avs_req_in.write) && st_q.bus_wait)
    begin
      st_d.bus_wait = 1'b0;
      st_d.rdata    = {24'h000000, rd_byte};
    end

    // Status read clears only the bits it returned, so later events survive
    if (avs_req_in.read && !st_q.bus_wait && idx == pwdc_pkg::REG_IRQ_STS)
    begin
      st_d.sts = st_q.sts & ~st_q.rdata[2:0];
    end

    if (acc_go)
    begin
      case (idx)
        pwdc_pkg::REG_OUT_CTRL: st_d.pwm_switch_off_bit = wdat[0];
        pwdc_pkg::REG_OUT_MODE: st_d.mode = wdat[1:0];
        pwdc_pkg::REG_MAP0:     st_d.map[0] = wdat;
        pwdc_pkg::REG_MAP1:     st_d.map[1] = wdat;
        pwdc_pkg::REG_MLP:      st_d.minimum_linear_pulse_length = wdat[6:0];
        pwdc_pkg::REG_SOFT_START:
        begin
          st_d.soft_start_enable_bit = wdat[pwdc_pkg::SS_EN_BIT];
          st_d.step_repeat_count     = wdat[6:0];
        end
        pwdc_pkg::REG_MOD_DUTY: st_d.mod_duty = wdat[6:0];
        pwdc_pkg::REG_DC_RESET: st_d.soft_rst = wdat[0];
        pwdc_pkg::REG_IRQ_MSK:  st_d.msk = wdat[2:0];
        default:
        begin
          if (idx >= pwdc_pkg::REG_CSUM_FIRST && idx <= pwdc_pkg::REG_CSUM_LAST)
            st_d.csum_ref[3'(idx - pwdc_pkg::REG_CSUM_FIRST)] = wdat;
        end
      endcase
    end

    // PWM period counter
    st_d.cnt = st_q.cnt + 7'h01;

    // Switch-on starts a whole period so the first pulse is never cut short
    if (st_q.pwm_switch_off_bit && !st_d.pwm_switch_off_bit)
    begin
      st_d.cnt = 7'h00;
    end

    // Soft start launch on switch-on with enable set, two-level modes only
    if (st_q.pwm_switch_off_bit && !st_d.pwm_switch_off_bit &&
        st_q.soft_start_enable_bit && st_q.mode != pwdc_pkg::MODE_BIASED)
    begin
      st_d.ss_act  = 1'b1;
      st_d.ss_duty = pwdc_pkg::SS_FIRST_DUTY;
      st_d.ss_rep  = 7'h00;
      st_d.cnt     = 7'h00;
    end
    else if (st_q.ss_act && wrap)
    begin
      if (st_q.ss_rep + 7'h01 >= st_q.step_repeat_count)
      begin
        st_d.ss_rep = 7'h00;
        if (st_q.ss_duty >= pwdc_pkg::HALF_DUTY)
        begin
          st_d.ss_act               = 1'b0;
          st_d.sts[pwdc_pkg::EV_SS_DONE] = 1'b1;
        end
        else
          st_d.ss_duty = st_q.ss_duty + 8'h01;
      end
      else
        st_d.ss_rep = st_q.ss_rep + 7'h01;
    end
    if (st_d.pwm_switch_off_bit)
      st_d.ss_act = 1'b0;

    // Per-period DC cut and index monitor
    if (wrap)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        xv = ACC_W'($signed({1'b0, pwm_duty_in[c]})) - $signed(ACC_W'(64));
        yv = xv - ($signed(st_q.acc[c]) >>> DC_SHIFT);
        st_d.acc[c] = st_q.acc[c] + yv;
        st_d.y[c]   = to_duty(yv);
        if (st_q.mod_duty != 7'h00 && abs_dev(pwm_duty_in[c]) >= {1'b0, st_q.mod_duty})
          mi_hit = 1'b1;
      end
      if (!mi_hit)
        st_d.mi_cnt = 16'h0000;
      else if (st_q.mi_cnt >= 16'(MOD_HOLD_PERIODS - 1))
      begin
        st_d.err[pwdc_pkg::ERR_MOD_BIT] = 1'b1;
        st_d.sts[pwdc_pkg::ERR_MOD_BIT] = 1'b1;
      end
      else
        st_d.mi_cnt = st_q.mi_cnt + 16'h0001;
    end

    // Checksum compare
    if (coef_sum_valid_in && coef_sum_in != st_q.csum_ref)
    begin
      st_d.err[pwdc_pkg::ERR_CSUM_BIT] = 1'b1;
      st_d.sts[pwdc_pkg::ERR_CSUM_BIT] = 1'b1;
    end

    // Pins follow switch-off only; error flags never gate them
    st_d.a = st_q.pwm_switch_off_bit ? 2'b00 : pair_a;
    st_d.b = st_q.pwm_switch_off_bit ? 2'b00 : pair_b;

    // Whole-block reinitialisation one cycle after the write
    if (st_q.soft_rst)
      st_d = rst_state();

    st_d.irq = |(st_d.sts & st_d.msk);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_q <= rst_state();
    else
      st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_readdata_out    = st_q.rdata;
  assign avs_waitrequest_out = st_q.bus_wait;
  assign bridge_output_a_out = st_q.a;
  assign bridge_output_b_out = st_q.b;
  assign dc_soft_reset_out   = st_q.soft_rst;
  assign irq_out             = st_q.irq;

endmodule : pwdc_out_prot

// ### rtl/pwdc_pkg.sv
// Shared constants and bus types for the PWM output and DC protection block
package pwdc_pkg;

  // ---------------------------------------------------------------
  // Bus
  // ---------------------------------------------------------------
  localparam int AW = 10;
  localparam int DW = 32;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [3:0]    byteenable;
    logic [DW-1:0] writedata;
  } pwdc_avs_req_s;

  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_OUT_CTRL   = 8'h34;
  localparam logic [7:0] REG_OUT_MODE   = 8'h35;
  localparam logic [7:0] REG_MAP0       = 8'h3e;
  localparam logic [7:0] REG_MAP1       = 8'h3f;
  localparam logic [7:0] REG_MLP        = 8'h43;
  localparam logic [7:0] REG_SOFT_START = 8'h4a;
  localparam logic [7:0] REG_MOD_DUTY   = 8'h51;
  localparam logic [7:0] REG_DC_RESET   = 8'h52;
  localparam logic [7:0] REG_CSUM_FIRST = 8'h53;
  localparam logic [7:0] REG_CSUM_LAST  = 8'h5a;
  localparam logic [7:0] REG_DC_ERR     = 8'h5b;
  localparam logic [7:0] REG_IRQ_STS    = 8'h60;
  localparam logic [7:0] REG_IRQ_MSK    = 8'h61;

  // ---------------------------------------------------------------
  // Fields and encodings
  // ---------------------------------------------------------------
  localparam int SS_EN_BIT    = 7;
  localparam int ERR_CSUM_BIT = 0;
  localparam int ERR_MOD_BIT  = 1;
  localparam int EV_SS_DONE   = 2;

  localparam logic [1:0] MODE_AD_ASYNC = 2'h0;
  localparam logic [1:0] MODE_AD_SYNC  = 2'h1;
  localparam logic [1:0] MODE_BIASED   = 2'h2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic       RST_OFF      = 1'b1;
  localparam logic [1:0] RST_MODE     = 2'h0;
  localparam logic [7:0] RST_MAP0     = 8'h00;
  localparam logic [7:0] RST_MAP1     = 8'h01;
  localparam logic [6:0] RST_MLP      = 7'h08;
  localparam logic [7:0] RST_SS       = 8'h00;
  localparam logic [6:0] RST_MOD_DUTY = 7'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_HZ        = 250000000;
  localparam int         PWM_STEPS     = 128;
  localparam logic [7:0] HALF_DUTY     = 8'h40;
  localparam logic [7:0] SS_FIRST_DUTY = 8'h01;
  localparam int         DC_CUT_HZ     = 1;
  // Leaky integrator shift: corner = period rate / (2 pi 2^shift), below DC_CUT_HZ
  localparam int         DC_CUT_SHIFT  = $clog2(CLK_HZ / (PWM_STEPS * 6 * DC_CUT_HZ));
  localparam int         MOD_HOLD_DEF  = 1024;

endpackage : pwdc_pkg

// ### rtl/pwdc_pair_gen.sv
// Waveform former for one bridge output pair
`timescale 1ns/10ps
module pwdc_pair_gen (
  input  wire logic [6:0] cnt_in,
  input  wire logic [7:0] duty_in,
  input  wire logic [1:0] mode_in,
  input  wire logic [6:0] mlp_in,
  output logic            a_out,
  output logic            b_out
);

  logic [7:0] pos;
  logic [7:0] neg;
  logic       lvl;

  always_comb
  begin
    pos = (duty_in > pwdc_pkg::HALF_DUTY) ? duty_in - pwdc_pkg::HALF_DUTY : 8'h00;
    neg = (duty_in < pwdc_pkg::HALF_DUTY) ? pwdc_pkg::HALF_DUTY - duty_in : 8'h00;
    lvl = {1'b0, cnt_in} < duty_in;
    case (mode_in)
      pwdc_pkg::MODE_AD_SYNC:
      begin
        a_out = lvl;
        b_out = lvl;
      end
      pwdc_pkg::MODE_BIASED:
      begin
        // Both legs idle at mlp width, signal adds to one leg only
        a_out = {1'b0, cnt_in} < ({1'b0, mlp_in} + pos);
        b_out = {1'b0, cnt_in} < ({1'b0, mlp_in} + neg);
      end
      default:
      begin
        a_out = lvl;
        b_out = ~lvl;
      end
    endcase
  end

endmodule : pwdc_pair_gen

// ### tb/pwdc_out_prot_properties.sv
// Port level checks of the PWM output and DC protection block
`timescale 1ns/10ps
module pwdc_out_prot_properties #(
  parameter int NCH              = 2,
  parameter int MOD_HOLD_PERIODS = 4,
  parameter int DC_SHIFT         = 4
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire pwdc_pkg::pwdc_avs_req_s avs_req_in,
  input  wire logic [31:0]             avs_readdata_out,
  input  wire logic                    avs_waitrequest_out,
  input  wire logic [NCH-1:0][7:0]     pwm_duty_in,
  input  wire logic [63:0]             coef_sum_in,
  input  wire logic                    coef_sum_valid_in,
  input  wire logic [1:0]              bridge_output_a_out,
  input  wire logic [1:0]              bridge_output_b_out,
  input  wire logic                    dc_soft_reset_out,
  input  wire logic                    irq_out
);
  // Shadow of the registers that steer the pins and the interrupt
  logic       done_w;
  logic [7:0] idx_w;
  logic [1:0] mode_q;
  logic       off_q;
  logic [2:0] mask_q;
  assign done_w = avs_req_in.write && !avs_waitrequest_out && avs_req_in.byteenable[0];
  assign idx_w  = avs_req_in.address[9:2];

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in || dc_soft_reset_out)
    begin
      mode_q <= 2'h0;
      off_q  <= 1'b1;
      mask_q <= 3'h0;
    end
    else if (done_w)
    begin
      if (idx_w == 8'h35) mode_q <= avs_req_in.writedata[1:0];
      if (idx_w == 8'h34) off_q <= avs_req_in.writedata[0];
      if (idx_w == 8'h61) mask_q <= avs_req_in.writedata[2:0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_req;
    (avs_req_in.read || avs_req_in.write) && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  sequence s_kill;
    done_w && idx_w == 8'h52 && avs_req_in.writedata[0];
  endsequence

  a_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus answer not after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_upper_zero: assert property (avs_req_in.read && !avs_waitrequest_out
    |-> avs_readdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_pins_off: assert property (off_q && $past(off_q)
    |-> bridge_output_a_out == 2'h0 && bridge_output_b_out == 2'h0)
    else $error("pins driven while switched off");
  a_pair_comp: assert property (!off_q && !$past(off_q) && !mode_q[1] && !mode_q[0]
    && $stable(mode_q) |-> bridge_output_b_out == ~bridge_output_a_out)
    else $error("pair not complementary");
  a_pair_same: assert property (!off_q && !$past(off_q) && mode_q == 2'h1
    && $stable(mode_q) |-> bridge_output_b_out == bridge_output_a_out)
    else $error("pair not identical");
  a_kill_pulse: assert property (s_kill |-> ##1 dc_soft_reset_out ##1 !dc_soft_reset_out)
    else $error("soft reset pulse wrong");
  a_kill_clears: assert property (dc_soft_reset_out |=> bridge_output_a_out == 2'h0
    && bridge_output_b_out == 2'h0 && !irq_out)
    else $error("state not cleared by soft reset");
  a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_out)
    else $error("interrupt while all masked");
endmodule : pwdc_out_prot_properties

bind pwdc_out_prot pwdc_out_prot_properties #(.NCH(NCH), .MOD_HOLD_PERIODS(MOD_HOLD_PERIODS),
  .DC_SHIFT(DC_SHIFT)) u_props (.clk_in(clk_in), .rst_in(rst_in), .avs_req_in(avs_req_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .pwm_duty_in(pwm_duty_in), .coef_sum_in(coef_sum_in), .coef_sum_valid_in(coef_sum_valid_in),
  .bridge_output_a_out(bridge_output_a_out), .bridge_output_b_out(bridge_output_b_out),
  .dc_soft_reset_out(dc_soft_reset_out), .irq_out(irq_out));

// ### tb/pwdc_stage_model.sv
// Power stage stand-in that measures pulse widths of output pair 0
`timescale 1ns/10ps
module pwdc_stage_model (
  input  wire logic       clk_in,
  input  wire logic       clear_in,
  input  wire logic [1:0] a_in,
  input  wire logic [1:0] b_in,
  output int              pulses_out,
  output int              last_len_out,
  output int              min_len_out
);
  int run_a;
  int run_b;
  always @(posedge clk_in)
  begin
    int m;
    m = min_len_out;
    if (clear_in)
    begin
      pulses_out <= 0;
      min_len_out <= 999;
      run_a <= 0;
      run_b <= 0;
    end
    else
    begin
      run_a <= a_in[0] ? run_a + 1 : 0;
      run_b <= b_in[0] ? run_b + 1 : 0;
      if (!a_in[0] && run_a > 0)
      begin
        pulses_out <= pulses_out + 1;
        last_len_out <= run_a;
        if (run_a < m) m = run_a;
      end
      if (!b_in[0] && run_b > 0 && run_b < m) m = run_b;
      min_len_out <= m;
    end
  end
endmodule : pwdc_stage_model

// ### tb/pwdc_out_prot_bench.sv
// Self-checking bench for the PWM output and DC protection block
`timescale 1ns/10ps
module pwdc_out_prot_bench;
  logic                    clk_in = 1'b0;
  logic                    rst_in = 1'b1;
  pwdc_pkg::pwdc_avs_req_s req = '0;
  logic [31:0]             rdata;
  logic                    wreq;
  logic [1:0][7:0]         duty = 16'h4040;
  logic [63:0]             csum = 64'h0;
  logic                    csum_v = 1'b0;
  logic [1:0]              pin_a;
  logic [1:0]              pin_b;
  logic                    irq;
  logic                    clr = 1'b1;
  int                      pulses, last_len, min_len;
  int                      n_errors = 0;
  int                      samples_checked = 0;
  int                      mdl[int];
  int                      ramp_q[$];
  logic [31:0]             seed = 32'h4ed9b723;
  logic [7:0]              ridx[11] = '{8'h34, 8'h35, 8'h3e, 8'h3f, 8'h43, 8'h4a, 8'h51,
                                        8'h5b, 8'h60, 8'h61, 8'h70};
  logic [7:0]              cidx[5] = '{8'h35, 8'h3e, 8'h3f, 8'h43, 8'h51};

  pwdc_out_prot #(.NCH(2), .MOD_HOLD_PERIODS(4), .DC_SHIFT(4)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .avs_req_in(req), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .pwm_duty_in(duty), .coef_sum_in(csum),
    .coef_sum_valid_in(csum_v), .bridge_output_a_out(pin_a), .bridge_output_b_out(pin_b),
    .dc_soft_reset_out(), .irq_out(irq));
  pwdc_stage_model u_stage (.clk_in(clk_in), .clear_in(clr), .a_in(pin_a), .b_in(pin_b),
    .pulses_out(pulses), .last_len_out(last_len), .min_len_out(min_len));

  initial
  begin
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int wmask(input logic [7:0] idx);
    if (idx >= 8'h53 && idx <= 8'h5a) return 8'hff;
    case (idx)
      8'h34: return 1;
      8'h35: return 3;
      8'h3e, 8'h3f, 8'h4a: return 8'hff;
      8'h43, 8'h51: return 8'h7f;
      8'h61: return 7;
      default: return 0;
    endcase
  endfunction : wmask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic fail_wait;
    n_errors++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 0, 1);
    complete_run();
  endtask : fail_wait

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pulse(input int got, input int exp);
    samples_checked++;
    if (got != exp)
    begin
      n_errors++;
      $display("Error at %0t: pulse got %h expected %h", $time, got, exp);
    end
  endtask : chk_pulse

  task automatic mdl_reset;
    mdl.delete();
    mdl[8'h34] = 1;
    mdl[8'h3f] = 1;
    mdl[8'h43] = 8;
  endtask : mdl_reset

  // ---------------------------------------------------------------
  // Bus master
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    req.read <= !wr;
    req.write <= wr;
    req.address <= {idx, 2'b00};
    req.byteenable <= {3'h7, be};
    req.writedata <= {24'h0, d};
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wreq !== 1'b0 && n < 100);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 100) fail_wait();
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, 1'b1, q);
    if (wmask(idx) != 0) mdl[idx] = d & wmask(idx);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, 1'b1, q);
    chk_reg(q, mdl.exists(idx) ? mdl[idx] : 0);
    if (idx == 8'h60) mdl[idx] = 0;
  endtask : rd

  task automatic run(input int cycles, input logic rnd);
    repeat (cycles)
    begin
      @(posedge clk_in);
      seed = lfsr(seed);
      if (rnd) duty <= {seed[15:8] > 8'h80 ? 8'h80 : seed[15:8], 1'b0, seed[6:0]};
    end
  endtask : run

  task automatic wait_pulses(input int target);
    int n;
    for (n = 0; n < 2000 && pulses < target; n++) @(posedge clk_in);
    if (n >= 2000) fail_wait();
  endtask : wait_pulses

  task automatic strobe;
    @(posedge clk_in);
    csum_v <= 1'b1;
    @(posedge clk_in);
    csum_v <= 1'b0;
    run(3, 1'b0);
  endtask : strobe

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    int n;
    mdl_reset();
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (ridx[i]) rd(ridx[i]);
    foreach (cidx[i])
    begin
      seed = lfsr(seed);
      wr(cidx[i], seed[7:0]);
      rd(cidx[i]);
    end
    bus(1'b1, 8'h35, 8'h02, 1'b0, q);
    rd(8'h35);
    wr(8'h5b, 8'hff);
    rd(8'h5b);
    wr(8'h51, 8'h00);
    wr(8'h35, 8'h00);
    wr(8'h61, 8'h04);
    wr(8'h4a, 8'h82);
    clr <= 1'b0;
    for (int k = 1; k <= 64; k++) repeat (2) ramp_q.push_back(k);
    wr(8'h34, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wait_pulses(i + 1);
      chk_pulse(last_len, ramp_q[i]);
    end
    for (n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge clk_in);
    if (n >= 20000) fail_wait();
    chk_reg({31'h0, irq}, 1);
    mdl[8'h60] = 4;
    rd(8'h60);
    rd(8'h60);
    wr(8'h35, 8'h01);
    run(400, 1'b1);
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h02);
    wr(8'h43, 8'h05);
    clr <= 1'b1;
    run(2, 1'b1);
    clr <= 1'b0;
    wr(8'h34, 8'h00);
    run(700, 1'b1);
    chk_pulse(int'(min_len >= 5 && pulses > 4), 1);
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      wr(8'(8'h53 + k), seed[7:0]);
      csum[8*k +: 8] <= seed[7:0];
    end
    strobe();
    rd(8'h5b);
    csum <= csum ^ 64'h1;
    strobe();
    mdl[8'h5b] = 1;
    mdl[8'h60] = 1;
    rd(8'h5b);
    chk_reg({31'h0, irq}, 0);
    wr(8'h61, 8'h01);
    run(3, 1'b1);
    chk_reg({31'h0, irq}, 1);
    rd(8'h60);
    run(3, 1'b1);
    chk_reg({31'h0, irq}, 0);
    rd(8'h5b);
    wr(8'h51, 8'h10);
    duty <= 16'h407f;
    run(1300, 1'b0);
    mdl[8'h5b] = 3;
    mdl[8'h60] = 2;
    rd(8'h5b);
    rd(8'h60);
    wr(8'h52, 8'h01);
    run(6, 1'b0);
    mdl_reset();
    foreach (ridx[i]) rd(ridx[i]);
    for (int k = 0; k < 8; k++) wr(8'(8'h53 + k), csum[8*k +: 8]);
    strobe();
    rd(8'h5b);
    complete_run();
  end
endmodule : pwdc_out_prot_bench
